// >>> verification/pbc_packet_buffer_chk.sv
// Purpose: Port-level assertions for the packet buffer controller.
// Assumes: Select inputs change only while srst is high.
// Notes: A frame counter mirrors the transmit queue to judge full and request.
`timescale 1ns/10ps
`default_nettype none

module pbc_packet_buffer_chk (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic ext_mem_select,
   input wire logic rx_in_drop,
   input wire logic rx_ready,
   input wire logic bulk_in_nak,
   input wire logic rx_out_valid,
   input wire logic tx_in_valid,
   input wire logic tx_in_ready,
   input wire logic tx_in_eop,
   input wire logic tx_full,
   input wire logic tx_req,
   input wire logic tx_out_valid,
   input wire logic tx_done,
   input wire logic sram_dq_oe,
   input wire logic sram_oe_n,
   input wire logic sram_we_n
);
   // ----------------------------------------------------------------
   // Frame mirror and properties
   // ----------------------------------------------------------------
   logic [2:0] frames_ff;
   logic [2:0] nxt_frames;

   always_comb begin
      nxt_frames = frames_ff;
      if (tx_in_valid && tx_in_ready && tx_in_eop) begin
         nxt_frames = nxt_frames + 3'h1;
      end
      if (tx_done && (frames_ff != 3'h0)) begin
         nxt_frames = nxt_frames - 3'h1;
      end
   end

   always_ff @(posedge ref_clk) begin
      frames_ff <= srst ? 3'h0 : nxt_frames;
   end

   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (srst);

   sequence s_frame_closed;
      tx_in_valid && tx_in_ready && tx_in_eop;
   endsequence
   sequence s_drop_once;
      rx_in_drop ##1 !rx_in_drop;
   endsequence

   nak_mirror_a: assert property (bulk_in_nak == !rx_ready)
      else $error("nak does not mirror rx ready");
   rx_gate_a: assert property (rx_out_valid |-> rx_ready)
      else $error("rx data offered before ready");
   tx_gate_a: assert property (tx_in_ready == !tx_full)
      else $error("tx ready does not follow full");
   frame_req_a: assert property (s_frame_closed |=> tx_req)
      else $error("no request after frame end");
   req_mirror_a: assert property (tx_req == (frames_ff != 3'h0))
      else $error("request disagrees with frame count");
   four_full_a: assert property ((frames_ff == 3'h4) |-> tx_full)
      else $error("four frames without full");
   drop_pulse_a: assert property ($rose(rx_in_drop) |-> s_drop_once)
      else $error("drop pulse too long");
   strobe_excl_a: assert property (!sram_oe_n |-> sram_we_n && !sram_dq_oe)
      else $error("read strobe overlaps a write");
   int_quiet_a: assert property (!ext_mem_select |-> sram_oe_n && sram_we_n)
      else $error("external strobes in internal mode");
   rst_state_a: assert property ($fell(srst) |-> bulk_in_nak && !tx_req && !tx_full && sram_we_n)
      else $error("outputs not idle after reset");
endmodule : pbc_packet_buffer_chk

bind pbc_packet_buffer pbc_packet_buffer_chk u_chk (.*);

`default_nettype wire

// >>> verification/pbc_packet_buffer_test.sv
// Purpose: Self-checking bench for the packet buffer controller.
// Assumes: Fixed seed; one byte moves per handshake.
// Notes: Expected drop counts come from the limits in the package.
`timescale 1ns/10ps
`default_nettype none

module pbc_packet_buffer_test;
   logic ref_clk, srst, ext_mem_select, rx_count_limit_select;
   logic rx_in_valid, rx_in_ready, rx_in_last, rx_in_drop, rx_ready, bulk_in_nak;
   logic rx_out_valid, rx_out_ready, rx_out_last, tx_in_valid, tx_in_ready, tx_in_eop;
   logic tx_full, tx_req, tx_out_valid, tx_out_ready, tx_out_last, tx_done;
   logic sram_dq_oe, sram_oe_n, sram_we_n, mem_drive, got_l;
   logic [7:0] rx_in_data, rx_out_data, tx_in_data, tx_out_data, sram_dq_o, sram_dq_i;
   logic [7:0] mem_q, got_d;
   logic [14:0] sram_addr;
   logic [7:0] rx_q[$], tx_q[$];
   logic rx_lq[$], tx_lq[$];
   int err_total, comparisons, drops;

   pbc_packet_buffer u_dut (.*);
   pbc_sram_model u_mem (.ref_clk(ref_clk), .addr(sram_addr), .dq(sram_dq_i),
      .oe_n(sram_oe_n), .we_n(sram_we_n), .drive(mem_drive), .q(mem_q));
   // Nobody driving leaves the weak pull-down in charge.
   assign sram_dq_i = sram_dq_oe ? sram_dq_o : (mem_drive ? mem_q : 8'h00);

   initial begin
      ref_clk = 1'b0;
      forever #2 ref_clk = ~ref_clk;
   end

   always @(negedge ref_clk) begin
      if (rx_in_drop === 1'b1) drops++;
   end

   // ----------------------------------------------------------------
   // Tasks
   // ----------------------------------------------------------------
   task automatic check(input logic [15:0] got, input logic [15:0] exp, input string what);
      comparisons++;
      if (got !== exp) begin
         err_total++;
         $display("wrong value at %0t: %s got %0h expected %0h", $time, what, got, exp);
      end
   endtask : check

   task automatic finish_test;
      $display("counts: %0d comparisons, %0d mismatches", comparisons, err_total);
      if (err_total == 0 && comparisons > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask : finish_test

   task automatic do_reset(input logic ext, input logic lim);
      ext_mem_select = ext;
      rx_count_limit_select = lim;
      srst = 1'b1;
      rx_q.delete();
      rx_lq.delete();
      tx_q.delete();
      tx_lq.delete();
      repeat (4) @(posedge ref_clk);
      #1 srst = 1'b0;
   endtask : do_reset

   // Selector: 0 rx in, 1 tx in, 2 rx out, 3 tx out; ready sides stall at random.
   task automatic wait_hs(input int sel);
      logic ok;
      int n;
      ok = 1'b0;
      n = 0;
      while (ok !== 1'b1) begin
         if (sel == 2) rx_out_ready = ($urandom % 3) != 0;
         if (sel == 3) tx_out_ready = ($urandom % 3) != 0;
         @(negedge ref_clk);
         case (sel)
            0: ok = rx_in_ready;
            1: ok = tx_in_ready;
            2: ok = rx_out_valid & rx_out_ready;
            default: ok = tx_out_valid & tx_out_ready;
         endcase
         got_d = (sel == 2) ? rx_out_data : tx_out_data;
         got_l = (sel == 2) ? rx_out_last : tx_out_last;
         @(posedge ref_clk);
         #1;
         n++;
         if (n > 500 && ok !== 1'b1) begin
            check(16'h0, 16'h1, "handshake stalled");
            ok = 1'b1;
         end
      end
   endtask : wait_hs

   function automatic int exp_keep(input int n, input int len);
      int k;
      int lim;
      k = int'(ext_mem_select ? pbc_pkg::MEM_EXT_BYTES : pbc_pkg::MEM_INT_BYTES) / len;
      lim = int'(rx_count_limit_select ? pbc_pkg::PKT_LIMIT_HI : pbc_pkg::PKT_LIMIT_LO);
      // The first packet's slot frees once its refill starts, so one more fits.
      if (lim + 1 < k) k = lim + 1;
      if (n < k) k = n;
      return k;
   endfunction : exp_keep

   task automatic run_rx(input int n, input int len, input bit drain);
      int keep;
      keep = exp_keep(n, len);
      drops = 0;
      for (int i = 0; i < n; i++) begin
         rx_in_valid = 1'b1;
         for (int j = 0; j < len; j++) begin
            rx_in_data = 8'($urandom);
            rx_in_last = (j == len - 1);
            if (i < keep) rx_q.push_back(rx_in_data);
            if (i < keep) rx_lq.push_back(rx_in_last);
            wait_hs(0);
         end
         rx_in_valid = 1'b0;
         repeat (300) @(posedge ref_clk);
         #1;
         if (i == 0) check(16'(bulk_in_nak), 16'h0, "nak after first packet");
      end
      check(16'(drops), 16'(n - keep), "dropped packets");
      while (drain && rx_q.size() > 0) begin
         wait_hs(2);
         check({8'h00, got_d}, {8'h00, rx_q.pop_front()}, "rx byte");
         check(16'(got_l), 16'(rx_lq.pop_front()), "rx last");
      end
      rx_out_ready = 1'b0;
      if (drain) check(16'(bulk_in_nak), 16'h1, "nak when drained");
   endtask : run_rx

   task automatic send_tx(input int len);
      tx_in_valid = 1'b1;
      for (int j = 0; j < len; j++) begin
         tx_in_data = 8'($urandom);
         tx_in_eop = (j == len - 1);
         tx_q.push_back(tx_in_data);
         tx_lq.push_back(tx_in_eop);
         wait_hs(1);
      end
      tx_in_valid = 1'b0;
      @(posedge ref_clk);
      #1;
   endtask : send_tx

   task automatic recv_tx;
      got_l = 1'b0;
      while (got_l !== 1'b1 && tx_q.size() > 0) begin
         wait_hs(3);
         check({8'h00, got_d}, {8'h00, tx_q.pop_front()}, "tx byte");
         check(16'(got_l), 16'(tx_lq.pop_front()), "tx last");
      end
      tx_out_ready = 1'b0;
      tx_done = 1'b1;
      @(posedge ref_clk);
      #1;
      tx_done = 1'b0;
   endtask : recv_tx

   initial begin
      repeat (95000) @(posedge ref_clk);
      err_total++;
      $display("wrong value at %0t: watchdog expired", $time);
      finish_test();
   end

   initial begin
      int n;
      {rx_in_valid, rx_in_last, rx_out_ready, tx_in_valid, tx_in_eop} = 5'h00;
      {tx_out_ready, tx_done, rx_in_data, tx_in_data} = 18'h00000;
      err_total = 0;
      comparisons = 0;
      void'($urandom(32'hD1C7));
      do_reset(1'b0, 1'b0);
      check(16'(bulk_in_nak), 16'h1, "nak out of reset");
      run_rx(18, 100, 1'b1);
      $display("test rx count limit done");
      do_reset(1'b1, 1'b1);
      run_rx(34, 100, 1'b1);
      $display("test external memory done");
      do_reset(1'b0, 1'b1);
      run_rx(26, 1000, 1'b0);
      $display("test rx capacity done");
      do_reset(1'b0, 1'b0);
      for (n = 0; n < 4; n++) send_tx(1 + int'($urandom % 40));
      check(16'(tx_full), 16'h1, "full at four frames");
      check(16'(tx_in_ready), 16'h0, "ready while full");
      recv_tx();
      check(16'(tx_full), 16'h0, "full after done");
      send_tx(5);
      for (n = 0; n < 4; n++) recv_tx();
      check(16'(tx_req), 16'h0, "request when empty");
      $display("test tx frames done");
      do_reset(1'b0, 1'b0);
      n = 0;
      tx_in_eop = 1'b0;
      tx_in_valid = 1'b1;
      while (n < 3000) begin
         tx_in_data = 8'($urandom);
         @(negedge ref_clk);
         if (tx_in_ready !== 1'b1) break;
         @(posedge ref_clk);
         #1;
         n++;
      end
      check(16'(n), 16'(pbc_pkg::TXF_BYTES), "bytes before full");
      @(posedge ref_clk);
      #1 tx_in_valid = 1'b0;
      $display("test tx bytes done");
      finish_test();
   end
endmodule : pbc_packet_buffer_test

`default_nettype wire

// >>> verification/pbc_sram_model.sv
// Purpose: Byte-wide external static memory facing the controller.
// Assumes: Writes land on every edge with the write strobe low.
// Notes: Bus resolution with the pull-down is done by the bench.
`timescale 1ns/10ps
`default_nettype none

module pbc_sram_model (
   input wire logic ref_clk,
   input wire logic [14:0] addr,
   input wire logic [7:0] dq,
   input wire logic oe_n,
   input wire logic we_n,
   output logic drive,
   output logic [7:0] q
);
   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   logic [7:0] mem [0:32767];

   // The last edge of a long strobe wins, like a real part latching at its end.
   always_ff @(posedge ref_clk) begin
      if (!we_n) begin
         mem[addr] <= dq;
      end
   end

   assign drive = !oe_n;
   assign q = mem[addr];
endmodule : pbc_sram_model

`default_nettype wire

// >>> verilog/pbc_packet_buffer.sv
// Purpose: Packet buffer between the USB endpoint decoder and the Ethernet MAC.
// Assumes: All inputs synchronous to ref_clk; select inputs change only while idle.
// Notes: Packet memory is a circular byte store; one memory access per cycle.
`timescale 1ns/10ps
`default_nettype none

module pbc_packet_buffer (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic ext_mem_select,
   input wire logic rx_count_limit_select,
   input wire logic rx_in_valid,
   output logic rx_in_ready,
   input wire logic [7:0] rx_in_data,
   input wire logic rx_in_last,
   output logic rx_in_drop,
   output logic rx_ready,
   output logic bulk_in_nak,
   output logic rx_out_valid,
   input wire logic rx_out_ready,
   output logic [7:0] rx_out_data,
   output logic rx_out_last,
   input wire logic tx_in_valid,
   output logic tx_in_ready,
   input wire logic [7:0] tx_in_data,
   input wire logic tx_in_eop,
   output logic tx_full,
   output logic tx_req,
   output logic tx_out_valid,
   input wire logic tx_out_ready,
   output logic [7:0] tx_out_data,
   output logic tx_out_last,
   input wire logic tx_done,
   output logic [14:0] sram_addr,
   output logic [7:0] sram_dq_o,
   output logic sram_dq_oe,
   input wire logic [7:0] sram_dq_i,
   output logic sram_oe_n,
   output logic sram_we_n
);

   // ----------------------------------------------------------------
   // State
   // ----------------------------------------------------------------
   typedef struct packed {
      logic [14:0] wr_ptr;
      logic [14:0] pkt_base;
      logic [15:0] cur_len;
      logic in_pkt;
      logic dropping;
      logic drop_pulse;
      logic [15:0] committed;
      logic [5:0] pkt_cnt;
      logic [4:0] dq_head;
      logic [4:0] dq_tail;
      logic [31:0][15:0] dq_len;
      logic [14:0] rd_ptr;
      logic [15:0] rd_rem;
      logic rd_busy;
      logic p1;
      logic p1_last;
      logic p2;
      logic p2_last;
      logic [7:0] rd_byte;
      logic [5:0] rf_wp;
      logic [5:0] rf_rp;
      logic [6:0] rf_cnt;
      logic [6:0] rf_eops;
      logic [10:0] tw_ptr;
      logic [11:0] t_cur;
      logic [12:0] t_used;
      logic [2:0] t_frames;
      logic [1:0] tq_head;
      logic [1:0] tq_tail;
      logic [3:0][11:0] tq_len;
      logic [10:0] t_base;
      logic [10:0] t_rd;
      logic [11:0] t_sent;
      pbc_pkg::pbc_sram_t sram;
   } pbc_state_t;

   pbc_state_t s_ff;
   pbc_state_t nxt_s;

   // ----------------------------------------------------------------
   // Storage and datapath wiring
   // ----------------------------------------------------------------
   logic [7:0] int_mem [int'(pbc_pkg::MEM_INT_BYTES)];
   pbc_pkg::pbc_beat_t rf_mem [int'(pbc_pkg::RXF_BYTES)];
   logic [7:0] tx_mem [int'(pbc_pkg::TXF_BYTES)];
   logic [7:0] int_rd_q;

   logic st_valid;
   logic st_ready;
   pbc_pkg::pbc_beat_t st_beat;
   pbc_pkg::pbc_beat_t rx_in_beat;

   logic [15:0] cap;
   logic [5:0] limit;
   logic mem_we;
   logic mem_re;
   logic [14:0] mem_addr;
   logic int_we;
   logic rf_we;
   logic tx_we;
   logic tx_pop;
   logic drop;
   logic [15:0] len;

   // Wraps a packet memory pointer at the size of the selected memory.
   function automatic logic [14:0] inc_wrap(input logic [14:0] p, input logic [15:0] c);
      logic [15:0] q;
      q = {1'b0, p} + 16'h0001;
      return (q == c) ? 15'h0000 : q[14:0];
   endfunction : inc_wrap

   // ----------------------------------------------------------------
   // Input staging
   // ----------------------------------------------------------------
   assign rx_in_beat.last = rx_in_last;
   assign rx_in_beat.data = rx_in_data;

   pbc_stage_fifo #(
      .WIDTH($bits(pbc_pkg::pbc_beat_t)),
      .DEPTH(pbc_pkg::STAGE_DEPTH)
   ) u_stage (
      .ref_clk(ref_clk),
      .srst(srst),
      .in_valid(rx_in_valid),
      .in_ready(rx_in_ready),
      .in_data(rx_in_beat),
      .out_valid(st_valid),
      .out_ready(st_ready),
      .out_data(st_beat)
   );

   // ----------------------------------------------------------------
   // Outputs
   // ----------------------------------------------------------------
   assign rx_ready = (s_ff.rf_cnt == pbc_pkg::RXF_BYTES) || (s_ff.rf_eops != 7'h00);
   assign bulk_in_nak = !rx_ready;
   assign rx_out_valid = rx_ready && (s_ff.rf_cnt != 7'h00);
   assign rx_out_data = rf_mem[s_ff.rf_rp].data;
   assign rx_out_last = rf_mem[s_ff.rf_rp].last;
   assign rx_in_drop = s_ff.drop_pulse;

   assign tx_full = (s_ff.t_frames == pbc_pkg::TX_FRAMES_MAX) ||
                    ((s_ff.t_used + 13'(s_ff.t_cur)) >= pbc_pkg::TXF_BYTES);
   assign tx_in_ready = !tx_full;
   assign tx_req = (s_ff.t_frames != 3'h0);
   assign tx_out_valid = tx_req && (s_ff.t_sent != s_ff.tq_len[s_ff.tq_head]);
   assign tx_out_last = (s_ff.t_sent + 12'h001) == s_ff.tq_len[s_ff.tq_head];
   assign tx_out_data = tx_mem[s_ff.t_rd];

   assign sram_addr = s_ff.sram.addr;
   assign sram_dq_o = s_ff.sram.dq_o;
   assign sram_dq_oe = s_ff.sram.dq_oe;
   assign sram_oe_n = s_ff.sram.oe_n;
   assign sram_we_n = s_ff.sram.we_n;

   // ----------------------------------------------------------------
   // Next state
   // ----------------------------------------------------------------
   always_comb begin
      nxt_s = s_ff;
      cap = ext_mem_select ? pbc_pkg::MEM_EXT_BYTES : pbc_pkg::MEM_INT_BYTES;
      limit = rx_count_limit_select ? pbc_pkg::PKT_LIMIT_HI : pbc_pkg::PKT_LIMIT_LO;
      mem_we = 1'b0;
      mem_re = 1'b0;
      mem_addr = s_ff.rd_ptr;
      drop = 1'b0;
      len = 16'h0000;
      nxt_s.drop_pulse = 1'b0;
      nxt_s.sram.we_n = 1'b1;
      nxt_s.sram.oe_n = 1'b1;
      nxt_s.sram.dq_oe = 1'b0;

      // ----------------------------------------------------------------
      // Receive write side
      // ----------------------------------------------------------------
      // The external strobe needs a recovery cycle, so the stage stalls
      // for one cycle after every external write.
      st_ready = !(ext_mem_select && !s_ff.sram.we_n);

      if (st_valid && st_ready) begin
         if (!s_ff.in_pkt) begin
            drop = (s_ff.pkt_cnt >= limit) || (s_ff.committed >= cap);
            nxt_s.pkt_base = s_ff.wr_ptr;
         end else begin
            drop = s_ff.dropping;
         end
         // A packet that outgrows the free space is also dropped whole.
         if ((s_ff.committed + s_ff.cur_len) >= cap) begin
            drop = 1'b1;
         end
         if (!drop) begin
            mem_we = 1'b1;
            mem_addr = s_ff.wr_ptr;
            nxt_s.wr_ptr = inc_wrap(s_ff.wr_ptr, cap);
         end
         len = s_ff.cur_len + 16'h0001;
         if (st_beat.last) begin
            if (drop) begin
               nxt_s.wr_ptr = s_ff.in_pkt ? s_ff.pkt_base : s_ff.wr_ptr;
               nxt_s.drop_pulse = 1'b1;
            end else begin
               nxt_s.dq_len[s_ff.dq_tail] = len;
               nxt_s.dq_tail = s_ff.dq_tail + 5'h01;
               nxt_s.committed = s_ff.committed + len;
               nxt_s.pkt_cnt = s_ff.pkt_cnt + 6'h01;
            end
            nxt_s.in_pkt = 1'b0;
            nxt_s.dropping = 1'b0;
            nxt_s.cur_len = 16'h0000;
         end else begin
            nxt_s.in_pkt = 1'b1;
            nxt_s.dropping = drop;
            nxt_s.cur_len = len;
         end
      end

      // ----------------------------------------------------------------
      // Refill side
      // ----------------------------------------------------------------
      // Refill side: start the next recorded packet in arrival order.
      // With 32 packets queued head and tail meet, so the count decides.
      if (!s_ff.rd_busy && (s_ff.pkt_cnt != 6'h00)) begin
         nxt_s.rd_rem = s_ff.dq_len[s_ff.dq_head];
         nxt_s.dq_head = s_ff.dq_head + 5'h01;
         nxt_s.pkt_cnt = nxt_s.pkt_cnt - 6'h01;
         nxt_s.rd_busy = 1'b1;
      end

      // Bytes in flight count against the 64-byte space before they land.
      nxt_s.p1 = 1'b0;
      nxt_s.p1_last = 1'b0;
      if (s_ff.rd_busy && !mem_we &&
          ((s_ff.rf_cnt + 7'(s_ff.p1) + 7'(s_ff.p2)) < pbc_pkg::RXF_BYTES)) begin
         mem_re = 1'b1;
         mem_addr = s_ff.rd_ptr;
         nxt_s.rd_ptr = inc_wrap(s_ff.rd_ptr, cap);
         nxt_s.rd_rem = s_ff.rd_rem - 16'h0001;
         nxt_s.committed = nxt_s.committed - 16'h0001;
         nxt_s.p1 = 1'b1;
         nxt_s.p1_last = (s_ff.rd_rem == 16'h0001);
         nxt_s.rd_busy = (s_ff.rd_rem != 16'h0001);
      end

      if (ext_mem_select && mem_we) begin
         nxt_s.sram.addr = mem_addr;
         nxt_s.sram.dq_o = st_beat.data;
         nxt_s.sram.dq_oe = 1'b1;
         nxt_s.sram.we_n = 1'b0;
      end else if (ext_mem_select && mem_re) begin
         nxt_s.sram.addr = mem_addr;
         nxt_s.sram.oe_n = 1'b0;
      end

      nxt_s.p2 = s_ff.p1;
      nxt_s.p2_last = s_ff.p1_last;
      if (s_ff.p1) begin
         nxt_s.rd_byte = ext_mem_select ? sram_dq_i : int_rd_q;
      end

      rf_we = s_ff.p2;
      if (rf_we) begin
         nxt_s.rf_wp = s_ff.rf_wp + 6'h01;
      end
      if (rx_out_valid && rx_out_ready) begin
         nxt_s.rf_rp = s_ff.rf_rp + 6'h01;
      end
      nxt_s.rf_cnt = s_ff.rf_cnt + 7'(rf_we) - 7'(rx_out_valid && rx_out_ready);
      nxt_s.rf_eops = s_ff.rf_eops + 7'(rf_we && s_ff.p2_last) -
                      7'(rx_out_valid && rx_out_ready && rx_out_last);

      // ----------------------------------------------------------------
      // Transmit side
      // ----------------------------------------------------------------
      // Transmit fill side.
      tx_we = tx_in_valid && tx_in_ready;
      if (tx_we) begin
         nxt_s.tw_ptr = s_ff.tw_ptr + 11'h001;
         if (tx_in_eop) begin
            nxt_s.tq_len[s_ff.tq_tail] = s_ff.t_cur + 12'h001;
            nxt_s.tq_tail = s_ff.tq_tail + 2'h1;
            nxt_s.t_frames = s_ff.t_frames + 3'h1;
            nxt_s.t_used = s_ff.t_used + 13'(s_ff.t_cur) + 13'h0001;
            nxt_s.t_cur = 12'h000;
         end else begin
            nxt_s.t_cur = s_ff.t_cur + 12'h001;
         end
      end

      // Transmit drain side.
      tx_pop = tx_out_valid && tx_out_ready;
      if (tx_pop) begin
         nxt_s.t_rd = s_ff.t_rd + 11'h001;
         nxt_s.t_sent = s_ff.t_sent + 12'h001;
      end
      if (tx_done && tx_req) begin
         nxt_s.t_frames = nxt_s.t_frames - 3'h1;
         nxt_s.t_used = nxt_s.t_used - 13'(s_ff.tq_len[s_ff.tq_head]);
         nxt_s.tq_head = s_ff.tq_head + 2'h1;
         nxt_s.t_base = s_ff.t_base + s_ff.tq_len[s_ff.tq_head][10:0];
         nxt_s.t_rd = nxt_s.t_base;
         nxt_s.t_sent = 12'h000;
      end
   end

   // ----------------------------------------------------------------
   // Registers
   // ----------------------------------------------------------------
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s_ff <= '0;
         s_ff.sram.we_n <= 1'b1;
         s_ff.sram.oe_n <= 1'b1;
      end else begin
         s_ff <= nxt_s;
      end
   end

   // ----------------------------------------------------------------
   // Storage
   // ----------------------------------------------------------------
   // Memories carry no reset; their contents are only read behind counts.
   always_comb begin
      int_we = mem_we && !ext_mem_select;
   end

   always_ff @(posedge ref_clk) begin
      if (int_we) begin
         int_mem[mem_addr] <= st_beat.data;
      end
      int_rd_q <= int_mem[mem_addr];
      if (rf_we) begin
         rf_mem[s_ff.rf_wp] <= '{last: s_ff.p2_last, data: s_ff.rd_byte};
      end
      if (tx_we) begin
         tx_mem[s_ff.tw_ptr] <= tx_in_data;
      end
   end

endmodule : pbc_packet_buffer

`default_nettype wire

// >>> verilog/pbc_pkg.sv
// Purpose: Shared constants and carriers for the packet buffer controller.
// Assumes: One clock, synchronous active-high reset.
// Notes: Memory sizes, packet limits and FIFO sizes live here only.

package pbc_pkg;

   // ----------------------------------------------------------------
   // Memory and limit sizes
   // ----------------------------------------------------------------
   localparam logic [15:0] MEM_INT_BYTES = 16'h6000;
   localparam logic [15:0] MEM_EXT_BYTES = 16'h8000;
   localparam logic [5:0] PKT_LIMIT_LO = 6'h10;
   localparam logic [5:0] PKT_LIMIT_HI = 6'h20;
   localparam logic [6:0] RXF_BYTES = 7'h40;
   localparam logic [12:0] TXF_BYTES = 13'h0800;
   localparam logic [2:0] TX_FRAMES_MAX = 3'h4;
   localparam int SRAM_AW = 15;
   localparam int STAGE_DEPTH = 4;

   // ----------------------------------------------------------------
   // Carriers
   // ----------------------------------------------------------------
   typedef struct packed {
      logic last;
      logic [7:0] data;
   } pbc_beat_t;

   typedef struct packed {
      logic [SRAM_AW-1:0] addr;
      logic [7:0] dq_o;
      logic dq_oe;
      logic oe_n;
      logic we_n;
   } pbc_sram_t;

endpackage : pbc_pkg

// >>> verilog/pbc_stage_fifo.sv
// Purpose: Small valid/ready FIFO staging bytes from the MAC.
// Assumes: Synchronous active-high reset; DEPTH is a power of two.
// Notes: Full and empty are exact; in_ready falls when full.
`timescale 1ns/10ps
`default_nettype none

module pbc_stage_fifo #(
   parameter int WIDTH = 9,
   parameter int DEPTH = 4
) (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic in_valid,
   output logic in_ready,
   input wire logic [WIDTH-1:0] in_data,
   output logic out_valid,
   input wire logic out_ready,
   output logic [WIDTH-1:0] out_data
);

   localparam int AW = $clog2(DEPTH);

   typedef struct packed {
      logic [AW-1:0] wp;
      logic [AW-1:0] rp;
      logic [AW:0] cnt;
   } pbc_sf_state_t;

   pbc_sf_state_t s_ff;
   pbc_sf_state_t nxt_s;
   logic [WIDTH-1:0] mem [DEPTH];
   logic push;
   logic pop;

   assign in_ready = (s_ff.cnt != (AW+1)'(DEPTH));
   assign out_valid = (s_ff.cnt != '0);
   assign out_data = mem[s_ff.rp];
   assign push = in_valid && in_ready;
   assign pop = out_valid && out_ready;

   always_comb begin
      nxt_s = s_ff;
      if (push) begin
         nxt_s.wp = s_ff.wp + 1'b1;
      end
      if (pop) begin
         nxt_s.rp = s_ff.rp + 1'b1;
      end
      nxt_s.cnt = s_ff.cnt + (AW+1)'(push) - (AW+1)'(pop);
   end

   always_ff @(posedge ref_clk) begin
      if (srst) begin
         s_ff <= '0;
      end else begin
         s_ff <= nxt_s;
      end
   end

   always_ff @(posedge ref_clk) begin
      if (push) begin
         mem[s_ff.wp] <= in_data;
      end
   end

endmodule : pbc_stage_fifo

`default_nettype wire
